// file: hdl/bcrc_pkg.sv
// Package for the byte CRC16 generator: register map, reset values, polynomials.
// Assumes a 32-bit APB slave with one aligned word per register.
package bcrc_pkg;
	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] BCRC_OFF_CTRL = 8'h00; // Polynomial control
	localparam logic [7:0] BCRC_OFF_INPUT = 8'h04; // Byte input
	localparam logic [7:0] BCRC_OFF_LOW = 8'h08; // Checksum low byte
	localparam logic [7:0] BCRC_OFF_HIGH = 8'h0C; // Checksum high byte
	// ==========================================================
	// Field positions and reset values
	localparam int BCRC_POLYNOMIAL_SELECT_BIT = 0; // Polynomial select position
	localparam logic [7:0] BCRC_RST_BYTE = 8'h00; // All registers reset to zero
	localparam logic [15:0] BCRC_RST_SUM = 16'h0000; // Checksum after reset
	// ==========================================================
	// Feedback constants
	localparam logic [15:0] BCRC_POLYNOMIAL_SELECT_CCITT = 16'h1021; // x16+x12+x5+1
	localparam logic [15:0] BCRC_POLYNOMIAL_SELECT_CRC16 = 16'h8005; // x16+x15+x2+1
	localparam int BCRC_STEPS = 8; // Bit steps per byte
	// ==========================================================
	// Update latency: one instruction cycle at 100 MHz
	localparam int BCRC_CYCLE_NS = 10; // Instruction cycle time, ns
	localparam int BCRC_CLK_NS = 10; // pclk period, ns
	localparam int BCRC_UPDATE_CYC = (BCRC_CYCLE_NS + BCRC_CLK_NS - 1) / BCRC_CLK_NS; // Longest wait in cycles
	// Polynomial choice
	typedef enum logic {
		BCRC_SEL_CCITT = 1'b0,
		BCRC_SEL_CRC16 = 1'b1
	} bcrc_sel_t;
	// APB request carried as one group
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bcrc_apb_req_t;
endpackage : bcrc_pkg

// file: hdl/bcrc_step.sv
// Combinational one-byte CRC fold: eight shift and feedback steps.
// Assumes the caller registers the result; no state here.
`timescale 1ns/1ps
module bcrc_step
	import bcrc_pkg::*;
#(
	parameter int STEPS = BCRC_STEPS
) (
	input wire logic [15:0] sum_in,
	input wire logic [7:0] data_in,
	input wire bcrc_sel_t polynomial_select_sel,
	output logic [15:0] sum_out
);
	// ==========================================================
	// Bit chain
	logic [15:0] stage [0:STEPS]; // Temporary value after each step
	logic [15:0] polynomial_select; // Selected feedback term
	// Feedback constant by select
	assign polynomial_select = (polynomial_select_sel == BCRC_SEL_CRC16) ? BCRC_POLYNOMIAL_SELECT_CRC16 : BCRC_POLYNOMIAL_SELECT_CCITT;
	// Byte folded into the high half first
	assign stage[0] = sum_in ^ {data_in, 8'h00};
	genvar gi;
	generate
		for (gi = 0; gi < STEPS; gi++) begin : g_step
			// Shift in zero, feed back when the top bit left was one
			assign stage[gi + 1] = {stage[gi][14:0], 1'b0} ^ (stage[gi][15] ? polynomial_select : 16'h0000);
		end
	endgenerate
	assign sum_out = stage[STEPS];
endmodule : bcrc_step

// file: hdl/bcrc_top.sv
// APB slave holding a byte-serial 16-bit CRC generator.
// Assumes an APB master on pclk; writes are zero wait state.
// Timing on the bus side:
// - every transfer has one setup cycle and one access cycle;
//   pready is a flip-flop that rises in the access cycle only
// - read data is captured at the setup edge, so the access
//   cycle already presents a settled register value
// - the fold is combinational and is stored at the same edge
//   that ends the write to the byte input, so the next read
//   of either checksum byte already sees the new value
// - a direct write to a checksum byte wins over a fold that
//   lands in the same cycle; with a single bus master the two
//   cannot meet, but the order keeps clearing always safe
// - writes with byte lane 0 off are dropped without an error
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module bcrc_top
	import bcrc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] checksum
);
	// ==========================================================
	// Bus decode
	// All strobes below are pure decode of the present bus cycle.
	// Writes act in the access cycle, reads are looked up in setup;
	// the slave never stretches a transfer, so there is no wait
	// state counter to keep in step with the master.
	bcrc_apb_req_t req; // Grouped request
	logic wr_acc; // Write access phase
	logic rd_setup; // Read setup phase
	logic wr_ctrl; // Write to control
	logic wr_input; // Write to byte input
	logic wr_low; // Write to low byte
	logic wr_high; // Write to high byte
	logic lane0; // Byte lane 0 enabled
	logic addr_ok; // Address is mapped
	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
	assign wr_acc = req.sel && req.enable && req.write;
	assign rd_setup = req.sel && !req.enable && !req.write;
	assign lane0 = pstrb[0];
	assign addr_ok = (req.addr == BCRC_OFF_CTRL) || (req.addr == BCRC_OFF_INPUT) ||
		(req.addr == BCRC_OFF_LOW) || (req.addr == BCRC_OFF_HIGH);
	assign wr_ctrl = wr_acc && lane0 && (req.addr == BCRC_OFF_CTRL);
	assign wr_input = wr_acc && lane0 && (req.addr == BCRC_OFF_INPUT);
	assign wr_low = wr_acc && lane0 && (req.addr == BCRC_OFF_LOW);
	assign wr_high = wr_acc && lane0 && (req.addr == BCRC_OFF_HIGH);
	// ==========================================================
	// Registers
	// Each register has its own process so that the priority of a
	// direct write over a fold is visible in one place per byte.
	// Everything resets to zero, which is also the value that
	// software loads before a new block.
	bcrc_sel_t polynomial_select_sel; // Polynomial select
	logic [7:0] crc_byte_input; // Last byte written
	logic [7:0] checksum_low_byte; // Running checksum low
	logic [7:0] checksum_high_byte; // Running checksum high
	logic [15:0] running_checksum; // Pair seen as one word
	logic [15:0] next_sum; // Folded result
	assign running_checksum = {checksum_high_byte, checksum_low_byte};
	// Fold engine works on the present sum and the incoming byte
	bcrc_step #(
		.STEPS(BCRC_STEPS)
	) u_step (
		.sum_in(running_checksum),
		.data_in(req.wdata[7:0]),
		.polynomial_select_sel(polynomial_select_sel),
		.sum_out(next_sum)
	);
	// Control register: only bit 0 is stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			polynomial_select_sel <= BCRC_SEL_CCITT;
		end else if (wr_ctrl) begin
			polynomial_select_sel <= bcrc_sel_t'(req.wdata[BCRC_POLYNOMIAL_SELECT_BIT]);
		end
	end
	// Input register keeps the byte for read-back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_byte_input <= BCRC_RST_BYTE;
		end else if (wr_input) begin
			crc_byte_input <= req.wdata[7:0];
		end
	end
	// Low checksum byte; a direct write wins over a fold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			checksum_low_byte <= BCRC_RST_SUM[7:0];
		end else if (wr_low) begin
			checksum_low_byte <= req.wdata[7:0];
		end else if (wr_input) begin
			checksum_low_byte <= next_sum[7:0];
		end
	end
	// High checksum byte; same precedence as the low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			checksum_high_byte <= BCRC_RST_SUM[15:8];
		end else if (wr_high) begin
			checksum_high_byte <= req.wdata[7:0];
		end else if (wr_input) begin
			checksum_high_byte <= next_sum[15:8];
		end
	end
	// ==========================================================
	// Read path: data captured in setup, no wait state on reads
	// so that prdata is a flip-flop and the access phase sees it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			unique case (req.addr)
				BCRC_OFF_CTRL: prdata <= {31'h0000_0000, polynomial_select_sel};
				BCRC_OFF_INPUT: prdata <= {24'h00_0000, crc_byte_input};
				BCRC_OFF_LOW: prdata <= {24'h00_0000, checksum_low_byte};
				BCRC_OFF_HIGH: prdata <= {24'h00_0000, checksum_high_byte};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
	// Ready: high in every access phase cycle; the setup capture
	// already made the read data valid, so no extra wait is needed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= req.sel && !req.enable;
			pslverr <= req.sel && !req.enable && !addr_ok;
		end
	end
	// Checksum mirror for the surrounding logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			checksum <= BCRC_RST_SUM;
		end else begin
			checksum <= {(wr_high ? req.wdata[7:0] : (wr_input ? next_sum[15:8] : checksum_high_byte)),
				(wr_low ? req.wdata[7:0] : (wr_input ? next_sum[7:0] : checksum_low_byte))};
		end
	end
	// ==========================================================
	// Checks
	localparam int BCRC_LAT = 1;
	property p_fold_ccitt;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && !wr_low && !wr_high && polynomial_select_sel == BCRC_SEL_CCITT && running_checksum == 16'h0000 &&
			req.wdata[7:0] == 8'h01) |=> (running_checksum == 16'h1021);
	endproperty
	a_fold_ccitt: assert property (p_fold_ccitt) else $error("CCITT fold of 01 wrong");
	property p_fold_crc16;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && polynomial_select_sel == BCRC_SEL_CRC16 && running_checksum == 16'h0000 &&
			req.wdata[7:0] == 8'h78) |=> (running_checksum == 16'h0110);
	endproperty
	a_fold_crc16: assert property (p_fold_crc16) else $error("CRC-16 fold of 78 wrong");
	property p_fold_seq;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && polynomial_select_sel == BCRC_SEL_CCITT && running_checksum == 16'hFF9F &&
			req.wdata[7:0] == 8'h56) |=> (running_checksum == 16'hBBC3);
	endproperty
	a_fold_seq: assert property (p_fold_seq) else $error("CCITT second byte wrong");
	property p_update_time;
		@(posedge pclk) disable iff (!presetn)
		wr_input |-> ##[1:BCRC_LAT] (running_checksum == $past(next_sum));
	endproperty
	a_update_time: assert property (p_update_time) else $error("Checksum not updated in time");
	property p_low_wins;
		@(posedge pclk) disable iff (!presetn)
		wr_low |=> (checksum_low_byte == $past(req.wdata[7:0]));
	endproperty
	a_low_wins: assert property (p_low_wins) else $error("Low byte write lost");
	property p_high_wins;
		@(posedge pclk) disable iff (!presetn)
		wr_high |=> (checksum_high_byte == $past(req.wdata[7:0]));
	endproperty
	a_high_wins: assert property (p_high_wins) else $error("High byte write lost");
	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr_input || wr_low || wr_high) |=> $stable(running_checksum);
	endproperty
	a_hold: assert property (p_hold) else $error("Checksum changed without a write");
	sequence s_ctrl_read;
		rd_setup && req.addr == BCRC_OFF_CTRL;
	endsequence
	property p_ctrl_zero;
		@(posedge pclk) disable iff (!presetn)
		s_ctrl_read |=> (prdata[31:1] == 31'h0000_0000 && prdata[0] == polynomial_select_sel);
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero) else $error("Control upper bits not zero");
	property p_mirror;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (checksum == running_checksum);
	endproperty
	a_mirror: assert property (p_mirror) else $error("Checksum output out of step");
	// ==========================================================
	// Bus handshake checks
	// A setup cycle, whatever its address or direction
	sequence s_setup;
		psel && !penable;
	endsequence
	// Ready follows every setup cycle in the very next cycle
	property p_ready_next;
		@(posedge pclk) disable iff (!presetn)
		s_setup |=> pready;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("Ready missing after setup");

	// Ready stands for one access cycle, never two in a row
	property p_ready_single;
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready;
	endproperty
	a_ready_single: assert property (p_ready_single) else $error("Ready held too long");

	// An unmapped address is answered with an error
	property p_err_unmapped;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !addr_ok) |=> (pslverr && pready);
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("Unmapped access not flagged");

	// A mapped address never reports an error
	property p_err_mapped;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && addr_ok) |=> !pslverr;
	endproperty
	a_err_mapped: assert property (p_err_mapped) else $error("Mapped access flagged");
	// ==========================================================
	// Register checks
	// Control write stores only the select bit
	property p_ctrl_write;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> (polynomial_select_sel == $past(req.wdata[BCRC_POLYNOMIAL_SELECT_BIT]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("Select bit not stored");

	// Byte input keeps the written byte for read-back
	property p_input_keep;
		@(posedge pclk) disable iff (!presetn)
		wr_input |=> (crc_byte_input == $past(req.wdata[7:0]));
	endproperty
	a_input_keep: assert property (p_input_keep) else $error("Input byte not kept");

	// A write with lane 0 off must not fold the checksum
	property p_masked_input;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && !lane0) |=> $stable(running_checksum);
	endproperty
	a_masked_input: assert property (p_masked_input) else $error("Masked write changed checksum");

	// Low byte read returns the register captured at setup
	property p_read_low;
		@(posedge pclk) disable iff (!presetn)
		(rd_setup && req.addr == BCRC_OFF_LOW) |=> (prdata == {24'h00_0000, $past(checksum_low_byte)});
	endproperty
	a_read_low: assert property (p_read_low) else $error("Low byte read wrong");

	// High byte read returns the register captured at setup
	property p_read_high;
		@(posedge pclk) disable iff (!presetn)
		(rd_setup && req.addr == BCRC_OFF_HIGH) |=> (prdata == {24'h00_0000, $past(checksum_high_byte)});
	endproperty
	a_read_high: assert property (p_read_high) else $error("High byte read wrong");
	// ==========================================================
	// Fold checks against fixed sums
	// A zero byte into a zero sum never triggers feedback
	property p_zero_fold;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && running_checksum == 16'h0000 && req.wdata[7:0] == 8'h00) |=> (running_checksum == 16'h0000);
	endproperty
	a_zero_fold: assert property (p_zero_fold) else $error("Zero fold not zero");

	// CRC-16 second byte of the known sequence
	property p_crc16_second;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && polynomial_select_sel == BCRC_SEL_CRC16 && running_checksum == 16'h0110 &&
			req.wdata[7:0] == 8'h56) |=> (running_checksum == 16'h91F1);
	endproperty
	a_crc16_second: assert property (p_crc16_second) else $error("CRC-16 second byte wrong");

	// CRC-16 last byte of the known sequence
	property p_crc16_last;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && polynomial_select_sel == BCRC_SEL_CRC16 && running_checksum == 16'hF2DE &&
			req.wdata[7:0] == 8'h12) |=> (running_checksum == 16'h5C43);
	endproperty
	a_crc16_last: assert property (p_crc16_last) else $error("CRC-16 last byte wrong");

	// CCITT third byte of the known sequence
	property p_ccitt_third;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && polynomial_select_sel == BCRC_SEL_CCITT && running_checksum == 16'hBBC3 &&
			req.wdata[7:0] == 8'h34) |=> (running_checksum == 16'hA367);
	endproperty
	a_ccitt_third: assert property (p_ccitt_third) else $error("CCITT third byte wrong");

	// CCITT last byte of the known sequence
	property p_ccitt_last;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && polynomial_select_sel == BCRC_SEL_CCITT && running_checksum == 16'hA367 &&
			req.wdata[7:0] == 8'h12) |=> (running_checksum == 16'hD0FA);
	endproperty
	a_ccitt_last: assert property (p_ccitt_last) else $error("CCITT last byte wrong");
endmodule : bcrc_top

// file: bench/bcrc_bench.sv
// Self-checking bench for the byte CRC16 generator, compared with an integer model.
// Assumes the APB slave answers with pready and keeps checksum equal to the register pair.
`timescale 1ns/1ps
module bcrc_bench;
	import bcrc_pkg::*;
	// ==========================================================
	// Signals and counters
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0] pstrb; // Byte lanes, lane 0 gates writes
	logic [15:0] checksum;
	logic rerr;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int model_sum; // Reference checksum
	int seq_b[4] = '{32'h78, 32'h56, 32'h34, 32'h12};
	int seq_c[4] = '{32'hFF9F, 32'hBBC3, 32'hA367, 32'hD0FA}; // Published CCITT sums
	int seq_r[4] = '{32'h0110, 32'h91F1, 32'hF2DE, 32'h5C43}; // Published CRC-16 sums
	bcrc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .checksum(checksum));
	// ==========================================================
	// Clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Whole run is well under a thousand transfers, so this only trips on a hang
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			results();
		end
	end
	// ==========================================================
	// Shared tasks
	task results();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Bit-serial fold written straight from the shift and feedback steps
	function automatic int fold(int s, int b, int p);
		s = s ^ (b << 8);
		for (int i = 0; i < 8; i++) begin
			s = s << 1;
			if (s & 32'h10000)
				s = (s ^ (p ? BCRC_POLYNOMIAL_SELECT_CRC16 : BCRC_POLYNOMIAL_SELECT_CCITT)) & 32'hFFFF;
		end
		return s;
	endfunction : fold
	// One APB transfer; entered just after a rising edge, leaves one edge after release
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rdat, rerr);
	endtask : wr
	task rd(input string what, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, rdat, rerr);
		chk(what, rdat, e);
	endtask : rd
	task feed(input int b, input int p);
		wr(BCRC_OFF_INPUT, 32'(b));
		model_sum = fold(model_sum, b, p);
		chk("checksum", {16'h0, checksum}, 32'(model_sum));
	endtask : feed
	task clr();
		wr(BCRC_OFF_LOW, 32'h0);
		wr(BCRC_OFF_HIGH, 32'h0);
		model_sum = 0;
	endtask : clr
	// ==========================================================
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		void'($urandom(61));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Every register starts at zero
		for (int a = 0; a < 4; a++)
			rd("reset value", 8'(a * 4), 32'h0);
		$display("test reset done");
		// Only the select bit is kept
		wr(BCRC_OFF_CTRL, 32'hFF);
		rd("control", BCRC_OFF_CTRL, 32'h01);
		wr(BCRC_OFF_CTRL, 32'hFE);
		rd("control", BCRC_OFF_CTRL, 32'h00);
		$display("test control done");
		// Single bytes from a cleared sum, both polynomials
		for (int p = 0; p < 2; p++) begin
			wr(BCRC_OFF_CTRL, 32'(p));
			for (int b = 0; b < 8; b++) begin
				clr();
				feed(b, p);
			end
		end
		$display("test single bytes done");
		// Published four-byte sequence, low and high read back
		for (int p = 0; p < 2; p++) begin
			wr(BCRC_OFF_CTRL, 32'(p));
			clr();
			for (int i = 0; i < 4; i++) begin
				feed(seq_b[i], p);
				chk("sequence", {16'h0, checksum}, 32'(p ? seq_r[i] : seq_c[i]));
			end
			rd("low", BCRC_OFF_LOW, 32'(model_sum & 32'hFF));
			rd("high", BCRC_OFF_HIGH, 32'(model_sum >> 8));
		end
		$display("test sequence done");
		// Random bytes and polynomials with direct seeding of the sum
		for (int i = 0; i < 32; i++) begin
			int p;
			int s;
			p = $urandom % 2;
			wr(BCRC_OFF_CTRL, 32'(p));
			if (i % 8 == 0) begin
				s = $urandom & 32'hFFFF;
				wr(BCRC_OFF_LOW, 32'(s & 32'hFF));
				wr(BCRC_OFF_HIGH, 32'(s >> 8));
				model_sum = s;
			end
			feed($urandom % 256, p);
		end
		// Program words: low byte first, then high byte
		wr(BCRC_OFF_CTRL, 32'h0);
		for (int w = 0; w < 4; w++) begin
			int w16;
			w16 = $urandom & 32'hFFFF;
			feed(w16 & 32'hFF, 0);
			feed(w16 >> 8, 0);
			rd("input", BCRC_OFF_INPUT, 32'(w16 >> 8));
		end
		$display("test random done");
		// Lane 0 off: the input write must not fold
		pstrb <= 4'hE;
		wr(BCRC_OFF_INPUT, 32'h5A);
		pstrb <= 4'hF;
		chk("masked write", {16'h0, checksum}, 32'(model_sum));
		// Unmapped place answers with an error and zero
		apb(1'b0, 8'h10, 32'h0, rdat, rerr);
		chk("unmapped error", {31'h0, rerr}, 32'h1);
		chk("unmapped data", rdat, 32'h0);
		$display("test refusals done");
		results();
	end
endmodule : bcrc_bench
